// [design/wdt_pkg.sv]
// Package for the low-frequency watchdog: register layout, reset values, mode codes.
// Assumes a single 20 MHz system clock domain; no other package is needed.
package wdt_pkg;
   // Register addresses on the plain register port
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_EVENT = 4'h2;
   localparam logic [3:0] ADDR_EV_CLEAR = 4'h3;
   localparam logic [3:0] ADDR_EV_ENABLE = 4'h4;
   // Control register fields
   localparam int CTL_ENABLE_BIT = 0;
   localparam int CTL_PERIOD_LSB = 1;
   localparam int PERIOD_WIDTH = 5;
   localparam logic [4:0] PERIOD_RESET = 5'h0B;
   localparam logic [4:0] PERIOD_MAX_VALID = 5'h12;
   localparam logic [0:0] ENABLE_RESET = 1'h0;
   // Prescale: code n gives ratio 2^(n+5)
   localparam int PRESCALE_BASE_SHIFT = 5;
   localparam int COUNT_WIDTH = 23;
   // Event bits
   localparam int EV_RESET_BIT = 0;
   localparam int EV_WAKE_BIT = 1;
   localparam int EV_WIDTH = 2;
   // Low-frequency oscillator and timing
   localparam int LFOSC_HZ = 31000;
   localparam int SYS_CLK_HZ = 20000000;
   localparam int BASE_INTERVAL_US = 1000;
   localparam int LF_TICK_CYCLES = SYS_CLK_HZ / LFOSC_HZ;
   // Configuration mode codes
   typedef enum logic [1:0] {
      WDT_MODE_OFF = 2'h0,
      WDT_MODE_SOFT = 2'h1,
      WDT_MODE_AWAKE = 2'h2,
      WDT_MODE_ON = 2'h3
   } wdt_mode_type;
endpackage

// [design/wdt_prescaler.sv]
// Prescaled watchdog counter clocked by low-frequency oscillator ticks.
// Assumes lf_tick is a one-cycle pulse in the system clock domain.
`timescale 1ns/10ps
module wdt_prescaler #(
   parameter int WIDTH = wdt_pkg::COUNT_WIDTH
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic clear,
   input wire logic lf_tick,
   input wire logic [4:0] period_code,
   output logic expire,
   output logic [WIDTH-1:0] count
);
   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;
   logic [WIDTH-1:0] terminal;
   logic [4:0] eff_code;
   logic hit;

   // Reserved codes fall back to the shortest interval
   assign eff_code = (period_code > wdt_pkg::PERIOD_MAX_VALID) ? 5'h00 : period_code;
   assign terminal = WIDTH'((32'h0000_0001 << (32'(eff_code) + wdt_pkg::PRESCALE_BASE_SHIFT)) - 32'h0000_0001);
   assign hit = lf_tick && (count_q == terminal);
   // Restart from zero after a single expiry pulse
   assign count_d = (clear || hit) ? '0 : (lf_tick ? count_q + 1'b1 : count_q);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         count_q <= '0;
         expire <= 1'b0;
      end else begin
         count_q <= count_d;
         expire <= hit && !clear;
      end
   end
   assign count = count_q;
endmodule

// [design/wdt_lowfreq.sv]
// Watchdog timer top: control/status registers, mode decode, clear network, reset and wake.
// Assumes all inputs synchronous to clk and a plain single-cycle register port.
//
// Behaviour
// - Counter advances on ticks of a 31 kHz oscillator modelled by dividing the system clock.
// - Reaching the selected time-out resets the device; firmware must clear in time.
// - Mode 11 keeps watchdog active always, Sleep included, ignoring the software enable.
// - Mode 10 runs while awake, stops in Sleep, ignores the software enable.
// - Mode 01 runs only with software enable set; Sleep leaves that unchanged.
// - Mode 00, or 01 with enable clear, holds the counter cleared.
// - A five-bit period field selects time-out from 1 ms to 256 s.
// - Reset loads the period field with the two second setting.
// - Any reset or clear-watchdog instruction clears the counter.
// - Entering Sleep clears the counter; counting resumes from zero if still enabled.
// - Wake clears the counter; crystal clocks hold it clear until start-up timer ends.
// - An oscillator failure report clears the counter.
// - Changing the internal oscillator divider leaves the counter alone.
// - Time-out in Sleep wakes instead of resetting and updates timeout and powerdown flags.
//
// Register map on the plain port:
//   0 control: bit 0 software enable, bits 5:1 period select, bits 7:6 read zero
//   1 status: bit 0 time-out flag, bit 1 powerdown flag, bit 2 watchdog running
//   2 event status: bit 0 reset event, bit 1 wake event, sticky until cleared
//   3 event clear: write ones to clear, reads zero
//   4 event enable: same layout as event status, drives irq
//   Other addresses read zero and ignore writes.
//
// Event timing:
//   The counter reaches its terminal value on a tick edge and raises expire.
//   One edge later wdt_reset_req or wdt_wake_req pulses for a single cycle,
//   the matching event bit sets and irq follows on the same edge if enabled.
//   The count restarts from zero on the expiry tick, so events repeat until cleared.
//
// Limitations:
//   The low-frequency tick is divided down from clk, so it drifts with the system clock
//   rather than standing on its own; TICK_CYCLES sets the ratio.
//   Sleep entry and wake arrive as one-cycle pulses from the power controller.
//   A shorter period written after the count has passed it waits for a wrap or a clear.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
module wdt_lowfreq #(
   parameter int TICK_CYCLES = wdt_pkg::LF_TICK_CYCLES,
   parameter int COUNT_WIDTH = wdt_pkg::COUNT_WIDTH
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic [1:0] config_watch_mode,
   input wire logic clear_watchdog_instr,
   input wire logic sleep_enter,
   input wire logic sleeping,
   input wire logic wake_event,
   input wire logic crystal_clock_sel,
   input wire logic osc_startup_timer,
   input wire logic osc_fail,
   input wire logic internal_osc_divider_change,
   output logic wdt_reset_req,
   output logic wdt_wake_req,
   output logic timeout_flag,
   output logic powerdown_flag,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////
   // Low-frequency tick generator
   // The oscillator is modelled as a divided pulse so no second domain exists.
   // Sixteen bits cover ratios up to 65536 of a slow oscillator against a fast system clock;
   // the count free-runs from reset and is never cleared by the watchdog itself.
   logic [15:0] tick_cnt_q;
   logic [15:0] tick_cnt_d;
   logic lf_tick;

   assign lf_tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));
   assign tick_cnt_d = lf_tick ? 16'h0000 : tick_cnt_q + 16'h0001;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         tick_cnt_q <= 16'h0000;
      end else begin
         tick_cnt_q <= tick_cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address decode
   // One function keeps every register select on the same compare.
   function automatic logic addr_hit(
      input logic [3:0] addr,
      input logic [3:0] target
   );
      addr_hit = (addr == target);
   endfunction

   logic sel_control;
   logic sel_status;
   logic sel_event;
   logic sel_ev_clear;
   logic sel_ev_enable;

   assign sel_control = addr_hit(reg_addr, wdt_pkg::ADDR_CONTROL);
   assign sel_status = addr_hit(reg_addr, wdt_pkg::ADDR_STATUS);
   assign sel_event = addr_hit(reg_addr, wdt_pkg::ADDR_EVENT);
   assign sel_ev_clear = addr_hit(reg_addr, wdt_pkg::ADDR_EV_CLEAR);
   assign sel_ev_enable = addr_hit(reg_addr, wdt_pkg::ADDR_EV_ENABLE);

   ////////////////////////////////////////////////////////////////////////////
   // Control register
   // Bits 7:6 are not stored; they read back as zero.
   // A write takes effect at the strobe edge while the counter keeps running.
   logic soft_watch_enable_q;
   logic [4:0] watch_period_select_q;
   logic ctl_write;
   logic wr_enable_bit;
   logic [4:0] wr_period_field;

   assign ctl_write = reg_write && sel_control;
   assign wr_enable_bit = reg_wdata[wdt_pkg::CTL_ENABLE_BIT];
   assign wr_period_field = reg_wdata[wdt_pkg::CTL_PERIOD_LSB +: wdt_pkg::PERIOD_WIDTH];

   always_ff @(posedge clk) begin
      if (!resetn) begin
         soft_watch_enable_q <= wdt_pkg::ENABLE_RESET;
         watch_period_select_q <= wdt_pkg::PERIOD_RESET;
      end else if (ctl_write) begin
         soft_watch_enable_q <= wr_enable_bit;
         watch_period_select_q <= wr_period_field;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode
   // The configuration mode is a fixed level in the field; a change to a quiet
   // mode clears the counter through the clear network below.
   wdt_pkg::wdt_mode_type mode;
   logic active;

   assign mode = wdt_pkg::wdt_mode_type'(config_watch_mode);

   always_comb begin
      case (mode)
         wdt_pkg::WDT_MODE_ON: begin
            active = 1'b1;
         end
         wdt_pkg::WDT_MODE_AWAKE: begin
            active = !sleeping;
         end
         wdt_pkg::WDT_MODE_SOFT: begin
            active = soft_watch_enable_q;
         end
         wdt_pkg::WDT_MODE_OFF: begin
            active = 1'b0;
         end
         default: begin
            active = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clear network
   // The divider change input is deliberately left out of the clear term.
   logic hold_ost;
   logic counter_clear;

   // Each cause has its own wire so a new clear source costs one line.
   logic clr_disabled;
   logic clr_instr;
   logic clr_sleep_entry;
   logic clr_wake;
   logic clr_fail;

   assign clr_disabled = !active;
   assign clr_instr = clear_watchdog_instr;
   assign clr_sleep_entry = sleep_enter;
   assign clr_wake = wake_event;
   // The start-up hold only matters after a wake, never while still asleep.
   assign hold_ost = crystal_clock_sel && osc_startup_timer && !sleeping;
   assign clr_fail = osc_fail;

   // Any single cause is enough; software cannot mask any of them.
   assign counter_clear = clr_disabled
      || clr_instr
      || clr_sleep_entry
      || clr_wake
      || hold_ost
      || clr_fail;
   logic unused_divider;
   assign unused_divider = internal_osc_divider_change;

   ////////////////////////////////////////////////////////////////////////////
   // Counter
   // The prescaled count lives in its own module so its width can follow the
   // largest ratio without touching the register logic.
   logic expire;
   logic [COUNT_WIDTH-1:0] wdt_count;

   wdt_prescaler #(
      .WIDTH(COUNT_WIDTH)
   ) u_prescaler (
      .clk(clk),
      .resetn(resetn),
      .clear(counter_clear),
      .lf_tick(lf_tick),
      .period_code(watch_period_select_q),
      .expire(expire),
      .count(wdt_count)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Reset, wake and status flags
   logic reset_ev;
   logic wake_ev;

   assign reset_ev = expire && !sleeping;
   assign wake_ev = expire && sleeping;

   ////////////////////////////////////////////////////////////////////////////
   // Status flags
   logic timeout_flag_d;
   logic powerdown_flag_d;

   // Expiry wins over a clear instruction in the same cycle so no time-out is lost.
   assign timeout_flag_d = expire ? 1'b1 :
      clear_watchdog_instr ? 1'b0 :
      timeout_flag;
   assign powerdown_flag_d = expire ? sleeping :
      clear_watchdog_instr ? 1'b0 :
      powerdown_flag;

   // Flags read active high: timeout_flag set on watchdog expiry,
   // powerdown_flag set while the expiry happened in Sleep.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wdt_reset_req <= 1'b0;
         wdt_wake_req <= 1'b0;
         timeout_flag <= 1'b0;
         powerdown_flag <= 1'b0;
      end else begin
         wdt_reset_req <= reset_ev;
         wdt_wake_req <= wake_ev;
         timeout_flag <= timeout_flag_d;
         powerdown_flag <= powerdown_flag_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event status, clear and enable
   logic [wdt_pkg::EV_WIDTH-1:0] ev_status_q;
   logic [wdt_pkg::EV_WIDTH-1:0] ev_enable_q;
   logic [wdt_pkg::EV_WIDTH-1:0] ev_set;
   logic [wdt_pkg::EV_WIDTH-1:0] ev_clr;
   logic [wdt_pkg::EV_WIDTH-1:0] ev_status_d;
   logic [wdt_pkg::EV_WIDTH-1:0] ev_enable_d;
   logic irq_d;
   logic wr_ev_clear;
   logic wr_ev_enable;

   assign ev_set[wdt_pkg::EV_RESET_BIT] = reset_ev;
   assign ev_set[wdt_pkg::EV_WAKE_BIT] = wake_ev;
   assign wr_ev_clear = reg_write && sel_ev_clear;
   assign wr_ev_enable = reg_write && sel_ev_enable;
   assign ev_clr = wr_ev_clear ? reg_wdata[wdt_pkg::EV_WIDTH-1:0] : '0;
   assign ev_enable_d = wr_ev_enable ? reg_wdata[wdt_pkg::EV_WIDTH-1:0] : ev_enable_q;

   // One sticky bit per event; set wins over a clear in the same cycle
   // so an expiry that lands on a software clear is never lost.
   for (genvar i = 0; i < wdt_pkg::EV_WIDTH; i++) begin : g_ev
      assign ev_status_d[i] = ev_set[i] || (ev_status_q[i] && !ev_clr[i]);
   end

   // Next status feeds the level so irq rises on the same edge as the event bit.
   assign irq_d = |(ev_status_d & ev_enable_q);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ev_status_q <= '0;
         ev_enable_q <= '0;
         irq <= 1'b0;
      end else begin
         ev_status_q <= ev_status_d;
         ev_enable_q <= ev_enable_d;
         irq <= irq_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port: data valid the cycle after the strobe
   logic [7:0] control_word;
   logic [7:0] status_word;
   logic [7:0] event_word;
   logic [7:0] enable_word;
   logic [7:0] rd_mux;
   logic [7:0] reg_rdata_d;

   assign control_word = {2'b00, watch_period_select_q, soft_watch_enable_q};
   assign status_word = {5'h00, active, powerdown_flag, timeout_flag};
   assign event_word = {6'h00, ev_status_q};
   assign enable_word = {6'h00, ev_enable_q};

   // Unmapped and write-only addresses read zero
   assign rd_mux = sel_control ? control_word :
      sel_status ? status_word :
      sel_event ? event_word :
      sel_ev_enable ? enable_word :
      8'h00;

   // Zero outside the read slot so a stale word never looks valid
   assign reg_rdata_d = reg_read ? rd_mux : 8'h00;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rdata_d;
      end
   end

   logic unused_count;
   assign unused_count = ^wdt_count;
endmodule

// [verif/wdt_props.sv]
// Checker for the watchdog top: time-out pulses, quiet modes, clearing, read port.
// Assumes it is bound onto wdt_lowfreq and sees only its ports.
`timescale 1ns/10ps
module wdt_props (
   input wire logic clk,
   input wire logic resetn,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic [1:0] config_watch_mode,
   input wire logic clear_watchdog_instr,
   input wire logic sleeping,
   input wire logic osc_fail,
   input wire logic wdt_reset_req,
   input wire logic wdt_wake_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////////
   one_event_a: assert property (!(wdt_reset_req && wdt_wake_req))
      else $error("reset and wake together");
   pulse_once_a: assert property (wdt_reset_req |=> !wdt_reset_req)
      else $error("reset request longer than one cycle");
   sleep_noreset_a: assert property (sleeping [*4] |-> !wdt_reset_req)
      else $error("reset request while asleep");
   off_silent_a: assert property ((config_watch_mode == 2'h0) [*4] |-> !(wdt_reset_req || wdt_wake_req))
      else $error("event with watchdog off");
   awake_only_a: assert property ((config_watch_mode == 2'h2 && sleeping) [*4] |-> !wdt_wake_req)
      else $error("wake in awake-only mode");
   osc_fail_a: assert property (osc_fail [*4] |-> !(wdt_reset_req || wdt_wake_req))
      else $error("event during oscillator failure");
   clear_holds_a: assert property (clear_watchdog_instr |-> ##3 !wdt_reset_req [*8])
      else $error("event right after clear");
   read_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
endmodule
bind wdt_lowfreq wdt_props u_props (.clk, .resetn, .reg_read, .reg_rdata, .config_watch_mode,
   .clear_watchdog_instr, .sleeping, .osc_fail, .wdt_reset_req, .wdt_wake_req);

// [verif/wdt_core_model.sv]
// Core model: issues clear-watchdog pulses every gap+1 cycles, or once on kick.
// Assumes the system clock; gap of zero stops the periodic clears.
`timescale 1ns/10ps
module wdt_core_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] gap,
   input wire logic kick,
   output logic clear_watchdog_instr
);
   logic [7:0] cnt_q;
   always_ff @(posedge clk) begin
      if (!resetn || gap == 8'h00 || cnt_q == gap) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
      clear_watchdog_instr <= resetn && (kick || (gap != 8'h00 && cnt_q == gap));
   end
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the watchdog with a short oscillator tick.
// Assumes TICK_CYCLES of 2, so code n times out after about 2^(n+6) clocks.
`timescale 1ns/10ps
module tb_top;
   logic clk = 0, resetn = 0, reg_write = 0, reg_read = 0, kick = 0, slp = 0, osc = 0, div = 0, se = 0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, gap = 8'h00, reg_rdata;
   logic [1:0] mode = 2'h3;
   logic clr, rst_req, wake_req, to_f, pd_f, irq;
   int fail_count = 0, tests_run = 0;
   always #25 clk = ~clk;
   // Divider selection keeps changing through every scenario
   always @(posedge clk) div <= ~div;
   wdt_core_model core_u (.clk(clk), .resetn(resetn), .gap(gap), .kick(kick), .clear_watchdog_instr(clr));
   wdt_lowfreq #(.TICK_CYCLES(2)) dut_u (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .config_watch_mode(mode), .clear_watchdog_instr(clr), .sleep_enter(se), .sleeping(slp),
      .wake_event(1'b0), .crystal_clock_sel(1'b0), .osc_startup_timer(1'b0), .osc_fail(osc),
      .internal_osc_divider_change(div), .wdt_reset_req(rst_req), .wdt_wake_req(wake_req),
      .timeout_flag(to_f), .powerdown_flag(pd_f), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      if (fail_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   // Counts clocks until either event; a full count means none came
   task automatic wait_ev(input int lim, output int n);
      @(posedge clk);
      kick <= 1'b1;
      @(posedge clk);
      kick <= 1'b0;
      n = 0;
      while (!(rst_req || wake_req) && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic s_period(input logic [7:0] ctl, input int exp);
      int n;
      wr(4'h0, ctl);
      wait_ev(exp + 40, n);
      chk({7'h00, rst_req}, 8'h01);
      chk({7'h00, n >= exp - 8 && n <= exp + 8}, 8'h01);
   endtask
   task automatic s_quiet(input logic [1:0] m, input logic s, input logic o);
      int n;
      @(posedge clk);
      mode <= m;
      slp <= s;
      osc <= o;
      wait_ev(150, n);
      chk({7'h00, n == 150}, 8'h01);
   endtask
   task automatic s_irq;
      wr(4'h4, 8'h03);
      s_period(8'h00, 64);
      repeat (3) @(posedge clk);
      #1;
      chk({7'h00, irq}, 8'h01);
      rd(4'h2, 8'h01);
      wr(4'h4, 8'h00);
      @(posedge clk);
      #1;
      chk({7'h00, irq}, 8'h00);
      wr(4'h4, 8'h03);
      wr(4'h3, 8'h03);
      repeat (2) @(posedge clk);
      #1;
      chk({7'h00, irq}, 8'h00);
   endtask
   task automatic s_sleep;
      int n;
      @(posedge clk);
      slp <= 1'b1;
      wait_ev(100, n);
      chk({7'h00, wake_req}, 8'h01);
      chk({6'h00, pd_f, to_f}, 8'h03);
      repeat (2) @(posedge clk);
      rd(4'h1, 8'h07);
   endtask
   task automatic s_entry;
      int ev;
      ev = 0;
      @(posedge clk);
      mode <= 2'h3;
      for (int n = 0; n < 150; n++) begin
         @(posedge clk);
         se <= (n % 40 == 39);
         #1;
         ev += int'(rst_req || wake_req);
      end
      @(posedge clk);
      se <= 1'b0;
      chk({7'h00, ev == 0}, 8'h01);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #300000;
      fail_count++;
      conclude();
   end
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      rd(4'h0, 8'h16);
      rd(4'hF, 8'h00);
      wr(4'h0, 8'hC2);
      rd(4'h0, 8'h02);
      s_irq();
      s_period(8'h02, 128);
      s_period(8'h26, 64);
      s_sleep();
      s_quiet(2'h2, 1'b1, 1'b0);
      s_quiet(2'h0, 1'b0, 1'b0);
      s_quiet(2'h3, 1'b0, 1'b1);
      s_quiet(2'h1, 1'b0, 1'b0);
      s_period(8'h01, 64);
      s_entry();
      gap <= 8'h28;
      s_quiet(2'h3, 1'b0, 1'b0);
      conclude();
   end
endmodule
